// File: nibble_arith_defines.vh
// Constants and operation codes for the nibble arithmetic datapath.
// Behaviour
// - Memory plus immediate plus carry into accumulator.
// - Accumulator plus immediate plus carry, status on overflow.
// - Memory plus accumulator plus carry into accumulator.
// - Add into selected address buffer nibble.
// - Add into selected data buffer nibble.
// - Memory minus immediate minus carry into accumulator.
// - Accumulator minus immediate minus carry, status on no-borrow.
// - Memory minus accumulator minus carry into accumulator.
// - Subtract from selected address buffer nibble.
// - Subtract from selected data buffer nibble.
// - Subtract immediate plus carry from Y or X.
// - Rotate accumulator right through carry flag.
// - Accumulator, X and Y are four bits.
// - Address buffer is fifteen bits, four nibbles.
// - Data buffer is sixteen bits, four nibbles.
// - Data memory addresses are eight bits wide.
// - Addition sets carry only on overflow.
// - Subtraction sets carry only on borrow.
// - Rotate sets status only when one shifted out.
`ifndef NIBBLE_ARITH_DEFINES_VH
`define NIBBLE_ARITH_DEFINES_VH

// Operation codes presented on OP.
`define OP_NONE 5'h00
`define OP_ADD_M_IMM 5'h01
`define OP_ADD_A_IMM 5'h02
`define OP_ADD_M_A 5'h03
`define OP_ADD_AB_IMM 5'h04
`define OP_ADD_AB_A 5'h05
`define OP_ADD_AB_Y 5'h06
`define OP_ADD_DB_IMM 5'h07
`define OP_ADD_DB_A 5'h08
`define OP_ADD_DB_Y 5'h09
`define OP_ADD_Y_IMM 5'h0A
`define OP_ADD_X_IMM 5'h0B
`define OP_SUB_M_IMM 5'h0C
`define OP_SUB_A_IMM 5'h0D
`define OP_SUB_M_A 5'h0E
`define OP_SUB_AB_IMM 5'h0F
`define OP_SUB_AB_A 5'h10
`define OP_SUB_AB_Y 5'h11
`define OP_SUB_DB_IMM 5'h12
`define OP_SUB_DB_A 5'h13
`define OP_SUB_DB_Y 5'h14
`define OP_SUB_Y_IMM 5'h15
`define OP_SUB_X_IMM 5'h16
`define OP_ROTATE 5'h17

// Widths of the datapath registers.
`define NIB_W 4
`define ADDR_BUF_W 15
`define DATA_BUF_W 16
`define MEM_ADDR_W 8

// Reset values.
`define NIB_RST 4'h0
`define ADDR_BUF_RST 15'h0000
`define DATA_BUF_RST 16'h0000
`define FLAG_RST 1'b0

// Operand selector codes used inside the datapath.
`define SRC_IMM 2'h0
`define SRC_ACC 2'h1
`define SRC_Y 2'h2

// Destination selector codes used inside the datapath.
`define DST_NONE 3'h0
`define DST_ACC 3'h1
`define DST_ABUF 3'h2
`define DST_DBUF 3'h3
`define DST_Y 3'h4
`define DST_X 3'h5

`endif

// File: nibble_arith_datapath.v
// Arithmetic datapath of the four-bit core: add, subtract and rotate.
`timescale 1ns/1ns
`default_nettype none
`include "nibble_arith_defines.vh"

module nibble_arith_datapath #(
    parameter NIB_WIDTH = `NIB_W,
    parameter MEM_AW = `MEM_ADDR_W
) (
    input wire CLK_SYS,
    input wire RST,
    input wire OP_VALID,
    input wire [4:0] OP,
    input wire [3:0] IMM,
    input wire [1:0] NIBBLE_SEL,
    input wire INDEX_FLAG,
    input wire [7:0] DATA_ADDRESS_POINTER,
    input wire [3:0] MEM_RDATA,
    output wire [7:0] MEM_ADDR,
    output wire [3:0] ACC,
    output wire [3:0] X_REG,
    output wire [3:0] Y_REG,
    output wire [14:0] ADDRESS_BUFFER,
    output wire [15:0] DATA_BUFFER,
    output wire CARRY_FLAG,
    output wire STATUS_FLAG
);

    ////////////////////////////////////////////////////////////////////////
    // Memory addressing.

    // Bits that widen a four-bit index register to the pointer width.
    localparam PAD_W = MEM_AW - NIB_WIDTH;

    wire [MEM_AW-1:0] x_ext;
    wire [MEM_AW-1:0] y_ext;
    wire [MEM_AW-1:0] indexed_addr;

    // Both index registers are zero-extended so that the sum is formed at the full pointer width.
    assign x_ext = {{PAD_W{1'b0}}, X_REG};
    assign y_ext = {{PAD_W{1'b0}}, Y_REG};
    // Indexed address is pointer plus X plus Y; the carry out of the top bit is dropped on purpose.
    assign indexed_addr = DATA_ADDRESS_POINTER + x_ext + y_ext;
    // The pointer alone is used unless the index flag is set.
    // The address is combinational, so a memory read sees the index values of this cycle.
    assign MEM_ADDR = INDEX_FLAG ? indexed_addr : DATA_ADDRESS_POINTER;

    ////////////////////////////////////////////////////////////////////////
    // Operation decode.

    reg is_sub;
    reg is_rot;
    reg [1:0] src_sel;
    reg [2:0] dst_sel;
    reg from_mem;

    // Split the operation into direction, operand source and destination.
    // Memory forms read the nibble at the current address in the same cycle, so
    // the decoder and the address path must settle within one clock period.
    always @*
    begin
        is_sub = 1'b0;
        is_rot = 1'b0;
        src_sel = `SRC_IMM;
        dst_sel = `DST_NONE;
        from_mem = 1'b0;
        case (OP)
            `OP_ADD_M_IMM:
            begin
                dst_sel = `DST_ACC;
                from_mem = 1'b1;
            end
            `OP_ADD_A_IMM: dst_sel = `DST_ACC;
            `OP_ADD_M_A:
            begin
                dst_sel = `DST_ACC;
                src_sel = `SRC_ACC;
                from_mem = 1'b1;
            end
            `OP_ADD_AB_IMM: dst_sel = `DST_ABUF;
            `OP_ADD_AB_A:
            begin
                dst_sel = `DST_ABUF;
                src_sel = `SRC_ACC;
            end
            `OP_ADD_AB_Y:
            begin
                dst_sel = `DST_ABUF;
                src_sel = `SRC_Y;
            end
            `OP_ADD_DB_IMM: dst_sel = `DST_DBUF;
            `OP_ADD_DB_A:
            begin
                dst_sel = `DST_DBUF;
                src_sel = `SRC_ACC;
            end
            `OP_ADD_DB_Y:
            begin
                dst_sel = `DST_DBUF;
                src_sel = `SRC_Y;
            end
            `OP_ADD_Y_IMM: dst_sel = `DST_Y;
            `OP_ADD_X_IMM: dst_sel = `DST_X;
            `OP_SUB_M_IMM:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_ACC;
                from_mem = 1'b1;
            end
            `OP_SUB_A_IMM:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_ACC;
            end
            `OP_SUB_M_A:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_ACC;
                src_sel = `SRC_ACC;
                from_mem = 1'b1;
            end
            `OP_SUB_AB_IMM:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_ABUF;
            end
            `OP_SUB_AB_A:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_ABUF;
                src_sel = `SRC_ACC;
            end
            `OP_SUB_AB_Y:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_ABUF;
                src_sel = `SRC_Y;
            end
            `OP_SUB_DB_IMM:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_DBUF;
            end
            `OP_SUB_DB_A:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_DBUF;
                src_sel = `SRC_ACC;
            end
            `OP_SUB_DB_Y:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_DBUF;
                src_sel = `SRC_Y;
            end
            `OP_SUB_Y_IMM:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_Y;
            end
            `OP_SUB_X_IMM:
            begin
                is_sub = 1'b1;
                dst_sel = `DST_X;
            end
            `OP_ROTATE: is_rot = 1'b1;
            default: dst_sel = `DST_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand selection and the four-bit adder.

    reg [3:0] lhs;
    reg [3:0] rhs;
    wire [3:0] abuf_nib;
    wire [3:0] dbuf_nib;
    wire [15:0] abuf_ext;
    wire [4:0] add_full;
    wire [4:0] sub_full;
    wire [3:0] result;
    wire carry_out;

    // The address buffer is widened by one zero bit so nibble 3 holds three bits.
    // A sum into nibble 3 may therefore set bit 15 of the widened copy; that bit
    // is dropped when the result is written back, and the carry, taken from bit four of the sum, does not show it.
    assign abuf_ext = {1'b0, ADDRESS_BUFFER};
    assign abuf_nib = abuf_ext[NIBBLE_SEL*4 +: 4];
    assign dbuf_nib = DATA_BUFFER[NIBBLE_SEL*4 +: 4];

    // Left operand is the destination or memory, right is the second operand.
    // For rotate and idle codes the adder output is computed but never stored.
    always @*
    begin
        case (dst_sel)
            `DST_ABUF: lhs = abuf_nib;
            `DST_DBUF: lhs = dbuf_nib;
            `DST_Y: lhs = Y_REG;
            `DST_X: lhs = X_REG;
            default: lhs = from_mem ? MEM_RDATA : ACC;
        endcase
        case (src_sel)
            `SRC_ACC: rhs = ACC;
            `SRC_Y: rhs = Y_REG;
            default: rhs = IMM;
        endcase
    end

    // Five-bit sums keep the carry or borrow apart from the wrapped result.
    // On subtract, bit four of the difference is set exactly when a borrow occurs.
    assign add_full = {1'b0, lhs} + {1'b0, rhs} + {4'h0, CARRY_FLAG};
    assign sub_full = {1'b0, lhs} - {1'b0, rhs} - {4'h0, CARRY_FLAG};
    assign result = is_sub ? sub_full[3:0] : add_full[3:0];
    assign carry_out = is_sub ? sub_full[4] : add_full[4];

    ////////////////////////////////////////////////////////////////////////
    // Nibble replacement for the buffers.

    wire [15:0] abuf_new;
    wire [15:0] dbuf_new;
    genvar gi;

    // Each nibble takes the result only when selected.
    // Only the selected nibble changes; the other three pass through unaltered.
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_nib
            assign abuf_new[gi*4 +: 4] = (NIBBLE_SEL == gi) ? result : abuf_ext[gi*4 +: 4];
            assign dbuf_new[gi*4 +: 4] = (NIBBLE_SEL == gi) ? result : DATA_BUFFER[gi*4 +: 4];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Rotate and flag values.

    wire [3:0] rot_acc;
    wire rot_out;
    wire arith_status;

    // Rotate does not use the adder, so its values are formed here on their own.
    // The old carry fills the top bit of the rotated accumulator.
    assign rot_acc = {CARRY_FLAG, ACC[3:1]};
    // The bit that leaves the accumulator becomes the new carry.
    assign rot_out = ACC[0];
    // Status follows the carry on add and is its inverse on subtract.
    assign arith_status = is_sub ? ~carry_out : carry_out;

    ////////////////////////////////////////////////////////////////////////
    // Register next values.

    reg [3:0] acc_d;
    reg [3:0] x_d;
    reg [3:0] y_d;
    reg [14:0] abuf_d;
    reg [15:0] dbuf_d;
    reg carry_d;
    reg status_d;

    // All flag and result values are formed from the registers as they stand
    // before this operation, so back-to-back operations each see the previous
    // result and the carry that it left behind.
    // Works out the next value of every register; idle cycles and unknown codes keep them all.
    always @*
    begin
        acc_d = ACC;
        x_d = X_REG;
        y_d = Y_REG;
        abuf_d = ADDRESS_BUFFER;
        dbuf_d = DATA_BUFFER;
        carry_d = CARRY_FLAG;
        status_d = STATUS_FLAG;
        if (OP_VALID)
        begin
            if (is_rot)
            begin
                acc_d = rot_acc;
                carry_d = rot_out;
                status_d = rot_out;
            end
            else if (dst_sel != `DST_NONE)
            begin
                // Add: carry and status on overflow; subtract: carry on borrow, status on no borrow.
                carry_d = carry_out;
                status_d = arith_status;
                case (dst_sel)
                    `DST_ACC: acc_d = result;
                    `DST_ABUF: abuf_d = abuf_new[14:0];
                    `DST_DBUF: dbuf_d = dbuf_new;
                    `DST_Y: y_d = result;
                    `DST_X: x_d = result;
                    default: acc_d = ACC;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register update.

    reg [3:0] acc_q;
    reg [3:0] x_q;
    reg [3:0] y_q;
    reg [14:0] abuf_q;
    reg [15:0] dbuf_q;
    reg carry_q;
    reg status_q;

    // Loads every register on each clock; reset clears them all to zero.
    // The synchronous reset wins over any operation presented in the same cycle.
    always @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            acc_q <= `NIB_RST;
            x_q <= `NIB_RST;
            y_q <= `NIB_RST;
            abuf_q <= `ADDR_BUF_RST;
            dbuf_q <= `DATA_BUF_RST;
            carry_q <= `FLAG_RST;
            status_q <= `FLAG_RST;
        end
        else
        begin
            acc_q <= acc_d;
            x_q <= x_d;
            y_q <= y_d;
            abuf_q <= abuf_d;
            dbuf_q <= dbuf_d;
            carry_q <= carry_d;
            status_q <= status_d;
        end
    end

    // Every result port is driven straight from its flip-flop.
    // Holding results in flip-flops keeps the ports free of adder glitches.
    assign ACC = acc_q;
    assign X_REG = x_q;
    assign Y_REG = y_q;
    assign ADDRESS_BUFFER = abuf_q;
    assign DATA_BUFFER = dbuf_q;
    assign CARRY_FLAG = carry_q;
    assign STATUS_FLAG = status_q;

endmodule

`default_nettype wire

// File: nibble_mem_model.sv
// Data memory seen by the datapath: a fixed pattern read combinationally.
`timescale 1ns/1ns
`default_nettype none
module nibble_mem_model (
    input wire logic [7:0] MEM_ADDR,
    output logic [3:0] MEM_RDATA
);
    // Each nibble differs from its neighbours, except 7F with 80 and FF with 00, so a wrong address shows up.
    function automatic logic [3:0] rd(input logic [7:0] a);
        rd = a[3:0] ^ a[7:4] ^ 4'hA;
    endfunction
    assign MEM_RDATA = rd(MEM_ADDR);
endmodule
`default_nettype wire

// File: nibble_arith_properties.sv
// Concurrent checks on the ports of the nibble arithmetic datapath.
`timescale 1ns/1ns
`default_nettype none
`include "nibble_arith_defines.vh"
module nibble_arith_properties (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic OP_VALID,
    input wire logic [4:0] OP,
    input wire logic [3:0] IMM,
    input wire logic INDEX_FLAG,
    input wire logic [7:0] DATA_ADDRESS_POINTER,
    input wire logic [3:0] MEM_RDATA,
    input wire logic [7:0] MEM_ADDR,
    input wire logic [3:0] ACC,
    input wire logic [3:0] X_REG,
    input wire logic [3:0] Y_REG,
    input wire logic CARRY_FLAG,
    input wire logic STATUS_FLAG
);
    // All checks run on the system clock and stop during reset.
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_op(logic [4:0] c); OP_VALID && OP == c; endsequence
    property p_addr; MEM_ADDR == (INDEX_FLAG ? DATA_ADDRESS_POINTER + X_REG + Y_REG : DATA_ADDRESS_POINTER); endproperty
    a_addr: assert property (p_addr) else $error("memory address wrong");
    property p_add_a; s_op(`OP_ADD_A_IMM) |=> {CARRY_FLAG, ACC} == $past(ACC) + $past(IMM) + $past(CARRY_FLAG)
        && STATUS_FLAG == CARRY_FLAG; endproperty
    a_add_a: assert property (p_add_a) else $error("accumulator add wrong");
    property p_sub_a; s_op(`OP_SUB_A_IMM) |=> {CARRY_FLAG, ACC} == $past(ACC) - $past(IMM) - $past(CARRY_FLAG)
        && STATUS_FLAG != CARRY_FLAG; endproperty
    a_sub_a: assert property (p_sub_a) else $error("accumulator subtract wrong");
    property p_add_m; s_op(`OP_ADD_M_A) |=> {CARRY_FLAG, ACC} == $past(MEM_RDATA) + $past(ACC) + $past(CARRY_FLAG); endproperty
    a_add_m: assert property (p_add_m) else $error("memory add wrong");
    property p_sub_m; s_op(`OP_SUB_M_IMM) |=> {CARRY_FLAG, ACC} == $past(MEM_RDATA) - $past(IMM) - $past(CARRY_FLAG); endproperty
    a_sub_m: assert property (p_sub_m) else $error("memory subtract wrong");
    property p_rot; s_op(`OP_ROTATE) |=> ACC == {$past(CARRY_FLAG), $past(ACC[3:1])}
        && CARRY_FLAG == $past(ACC[0]) && STATUS_FLAG == CARRY_FLAG; endproperty
    a_rot: assert property (p_rot) else $error("rotate wrong");
    property p_add_y; s_op(`OP_ADD_Y_IMM) |=> {CARRY_FLAG, Y_REG} == $past(Y_REG) + $past(IMM) + $past(CARRY_FLAG); endproperty
    a_add_y: assert property (p_add_y) else $error("Y add wrong");
    property p_sub_x; s_op(`OP_SUB_X_IMM) |=> {CARRY_FLAG, X_REG} == $past(X_REG) - $past(IMM) - $past(CARRY_FLAG); endproperty
    a_sub_x: assert property (p_sub_x) else $error("X subtract wrong");
    property p_hold; !OP_VALID |=> $stable(ACC) && $stable(X_REG) && $stable(CARRY_FLAG); endproperty
    a_hold: assert property (p_hold) else $error("state changed while idle");
endmodule
`default_nettype wire

// File: nibble_arith_datapath_tb.sv
// Self-checking testbench for the nibble arithmetic datapath.
`timescale 1ns/1ns
`default_nettype none
`include "nibble_arith_defines.vh"
module nibble_arith_datapath_tb;
    logic clk = 0, rst = 1, vld = 0, idx = 0, cy, st, mc, ms;
    logic [4:0] op = 0;
    logic [3:0] imm = 0, rdata, acc, xr, yr, ma, mx, my;
    logic [1:0] sel = 0;
    logic [7:0] ptr = 0, addr;
    logic [14:0] ab, mab;
    logic [15:0] db, mdb;
    logic [44:0] exp_q[$];
    logic [7:0] addr_q[$];
    int bad_count = 0, comparisons = 0, cycles = 0;
    // Clock of 100 ns period.
    always #50 clk = ~clk;
    nibble_arith_datapath u_nibble_arith_datapath (.CLK_SYS(clk), .RST(rst), .OP_VALID(vld), .OP(op), .IMM(imm),
        .NIBBLE_SEL(sel), .INDEX_FLAG(idx), .DATA_ADDRESS_POINTER(ptr), .MEM_RDATA(rdata), .MEM_ADDR(addr),
        .ACC(acc), .X_REG(xr), .Y_REG(yr), .ADDRESS_BUFFER(ab), .DATA_BUFFER(db), .CARRY_FLAG(cy), .STATUS_FLAG(st));
    nibble_mem_model u_nibble_mem_model (.MEM_ADDR(addr), .MEM_RDATA(rdata));
    task chk(input string n, input logic [44:0] e, input logic [44:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_addr(input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED memory address expected %h seen %h", e, g);
        end
    endtask
    task results;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task do_reset;
        @(posedge clk);
        {rst, vld} <= 2'h2;
        repeat (3) @(posedge clk);
        rst <= 0;
        {ma, mx, my, mab, mdb, mc, ms} = 0;
        #1 chk("reset", 0, {acc, xr, yr, ab, db, cy, st});
    endtask
    // Drives one operation and notes the state it must leave behind.
    task step(input logic [4:0] o);
        logic [3:0] i, d, v, m;
        logic [1:0] n;
        logic f, sub;
        logic [7:0] p;
        logic [15:0] b;
        logic [4:0] t;
        logic [2:0] dst;
        logic [7:0] ea;
        i = $urandom;
        n = $urandom;
        f = $urandom;
        p = $urandom;
        b = {1'b0, mab};
        ea = f ? p + mx + my : p;
        m = u_nibble_mem_model.rd(ea);
        case (o)
            `OP_ADD_M_IMM, `OP_SUB_M_IMM: {dst, d, v} = {`DST_ACC, m, i};
            `OP_ADD_A_IMM, `OP_SUB_A_IMM: {dst, d, v} = {`DST_ACC, ma, i};
            `OP_ADD_M_A, `OP_SUB_M_A: {dst, d, v} = {`DST_ACC, m, ma};
            `OP_ADD_AB_IMM, `OP_SUB_AB_IMM: {dst, d, v} = {`DST_ABUF, b[n*4 +: 4], i};
            `OP_ADD_AB_A, `OP_SUB_AB_A: {dst, d, v} = {`DST_ABUF, b[n*4 +: 4], ma};
            `OP_ADD_AB_Y, `OP_SUB_AB_Y: {dst, d, v} = {`DST_ABUF, b[n*4 +: 4], my};
            `OP_ADD_DB_IMM, `OP_SUB_DB_IMM: {dst, d, v} = {`DST_DBUF, mdb[n*4 +: 4], i};
            `OP_ADD_DB_A, `OP_SUB_DB_A: {dst, d, v} = {`DST_DBUF, mdb[n*4 +: 4], ma};
            `OP_ADD_DB_Y, `OP_SUB_DB_Y: {dst, d, v} = {`DST_DBUF, mdb[n*4 +: 4], my};
            `OP_ADD_Y_IMM, `OP_SUB_Y_IMM: {dst, d, v} = {`DST_Y, my, i};
            `OP_ADD_X_IMM, `OP_SUB_X_IMM: {dst, d, v} = {`DST_X, mx, i};
            `OP_ROTATE: dst = 3'h7;
            default: dst = `DST_NONE;
        endcase
        // Borrow is bit four of the five-bit difference.
        sub = o >= `OP_SUB_M_IMM && o <= `OP_SUB_X_IMM;
        t = sub ? d - v - mc : d + v + mc;
        if (dst == 3'h7)
            {ma, mc, ms} = {mc, ma, ma[0]};
        else if (dst != `DST_NONE)
            {mc, ms} = {t[4], t[4] ^ sub};
        case (dst)
            `DST_ACC: ma = t[3:0];
            `DST_ABUF: b[n*4 +: 4] = t[3:0];
            `DST_DBUF: mdb[n*4 +: 4] = t[3:0];
            `DST_Y: my = t[3:0];
            `DST_X: mx = t[3:0];
            default: ;
        endcase
        mab = b[14:0];
        @(posedge clk);
        {vld, op, imm, sel, idx, ptr} <= {1'b1, o, i, n, f, p};
        exp_q.push_back({ma, mx, my, mab, mdb, mc, ms});
        addr_q.push_back(ea);
    endtask
    // Compares the memory address in the middle of the cycle in which each operation is presented.
    always @(negedge clk)
    begin
        if (vld === 1'b1 && rst === 1'b0)
            chk_addr(addr_q.pop_front(), addr);
    end
    // Compares each taken operation with the oldest noted state.
    always @(posedge clk)
    begin
        if (vld === 1'b1 && rst === 1'b0)
            #1 chk("state", exp_q.pop_front(), {acc, xr, yr, ab, db, cy, st});
    end
    // Cuts a hung run short.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            results;
        end
    end
    // Main sequence: every code, random back-to-back traffic, reset in mid-run.
    initial
    begin
        void'($urandom(20216));
        do_reset;
        for (int k = 0; k < 32; k++)
            step(k[4:0]);
        $display("Test of all codes done");
        repeat (400) step(5'($urandom_range(23, 1)));
        $display("Test of random operations done");
        do_reset;
        repeat (100) step(5'($urandom_range(31, 0)));
        @(posedge clk);
        vld <= 0;
        repeat (2) @(posedge clk);
        $display("Test of reset in mid-run done");
        results;
    end
endmodule
bind nibble_arith_datapath nibble_arith_properties u_props (.CLK_SYS(CLK_SYS), .RST(RST), .OP_VALID(OP_VALID),
    .OP(OP), .IMM(IMM), .INDEX_FLAG(INDEX_FLAG), .DATA_ADDRESS_POINTER(DATA_ADDRESS_POINTER), .MEM_RDATA(MEM_RDATA),
    .MEM_ADDR(MEM_ADDR), .ACC(ACC), .X_REG(X_REG), .Y_REG(Y_REG), .CARRY_FLAG(CARRY_FLAG), .STATUS_FLAG(STATUS_FLAG));
`default_nettype wire
